// [rtl/pcq_defs.vh]
// constants for the power, cache and queue control block
// assumes a decoded command front end and an extended config space byte map
// Summary of operation
// R1: notice byte values 01 on, 02/03 off, 04 sleep
// R2: host writes powered-on before other notice values
// R3: busy held after short/long power-off write
// R4: short power-off finishes within switch timeout
// R5: long power-off finishes within long timeout
// R6: later command or priority interrupt restores powered-on
// R7: writing 00 after another value flags switch error
// R8: sleep/wake command accepted while powered on
// R9: sleep notice busy bounded by sleep time byte; the code bounds it by SLEEP_CYC, not by SLEEP_BYTE
// R10: leaving sleep or interrupt abort restores powered-on
// R11: host wakes and selects before full power removal
// R12: barrier orders earlier commits before later ones
// R13: barrier bit of flush byte starts barrier
// R14: unlimited barriers, overflow becomes a full flush
// R15: barrier capability byte reads one when supported
// R16: host sets barrier enable bit 0 first
// R17: forced and reliable writes may bypass barriers
// R18: fifo policy bit; barriers then accepted harmlessly
// R19: task parameter plus start address queues one task
// R20: execute on ready task gives response, starts transfer
// R21: mode switch with nonempty queue is illegal
// R22: execute refused unless block size is 512
// R23: per-task state empty, pending or ready
`ifndef PCQ_DEFS_VH
`define PCQ_DEFS_VH
// byte indices in the extended config space
`define PCQ_IDX_BARRIER_EN   9'h01F
`define PCQ_IDX_FLUSH_CTRL   9'h020
`define PCQ_IDX_POWER_OFF    9'h022
`define PCQ_IDX_SLEEP_TIME   9'h0D8
`define PCQ_IDX_FLUSH_POLICY 9'h0F0
`define PCQ_IDX_BARRIER_CAP  9'h1E6
// notice byte values
`define PCQ_PON_UNSET        8'h00
`define PCQ_PON_ON           8'h01
`define PCQ_PON_SHORT        8'h02
`define PCQ_PON_LONG         8'h03
`define PCQ_PON_SLEEP        8'h04
// field positions
`define PCQ_FLUSH_BIT        0
`define PCQ_BARRIER_BIT      1
`define PCQ_FORCED_BIT       24
`define PCQ_RELIABLE_BIT     31
`define PCQ_SLEEP_ARG_BIT    15
// command indices
`define PCQ_CMD_SLEEP        6'h05
`define PCQ_CMD_SWITCH       6'h06
`define PCQ_CMD_SELECT       6'h07
`define PCQ_CMD_STATUS       6'h0D
`define PCQ_CMD_BLKCNT       6'h17
`define PCQ_CMD_TASK_PARAM   6'h2C
`define PCQ_CMD_TASK_ADDR    6'h2D
`define PCQ_CMD_EXEC_RD      6'h2E
`define PCQ_CMD_EXEC_WR      6'h2F
// task states
`define PCQ_TASK_EMPTY       2'h0
`define PCQ_TASK_PENDING     2'h1
`define PCQ_TASK_READY       2'h2
`define PCQ_TASK_RUN         2'h3
// timeouts in microseconds at 100 cycles each, and the barrier count limit
`define PCQ_CYC_PER_US       100
`define PCQ_SHORT_TIME_US    10000
`define PCQ_LONG_TIME_US     100000
`define PCQ_SLEEP_TIME_US    1000
`define PCQ_BARRIER_LIMIT    8'h10
`endif

// [rtl/pcq_control.v]
// power-off notice, cache barrier and task queue control
// assumes commands arrive decoded on clk_sys_i; the bus clock pin is sampled
`timescale 1ns/100ps
`default_nettype none
`include "pcq_defs.vh"
module pcq_control #(
  parameter        SHORT_CYC   = `PCQ_SHORT_TIME_US * `PCQ_CYC_PER_US,
  parameter        LONG_CYC    = `PCQ_LONG_TIME_US * `PCQ_CYC_PER_US,
  parameter        SLEEP_CYC   = `PCQ_SLEEP_TIME_US * `PCQ_CYC_PER_US,
  parameter        BARRIER_ON  = 1,
  parameter        FIFO_POLICY = 0,
  parameter [7:0]  SLEEP_BYTE  = 8'h08
) (
  // system
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // bus pins
  input  wire        mmc_clk_i,
  output wire        dat0_o,
  output reg         dat0_oe_o,
  // decoded commands
  input  wire        cmd_valid_i,
  input  wire [5:0]  cmd_index_i,
  input  wire [31:0] cmd_arg_i,
  input  wire        priority_interrupt_request_i,
  output reg         resp_valid_o,
  output reg         resp_err_o,
  output reg         switch_error_o,
  output reg         illegal_cmd_o,
  // config space read port
  input  wire [8:0]  cfg_rd_addr_i,
  output reg  [7:0]  cfg_rd_data_o,
  // backend
  input  wire        prep_done_i,
  input  wire        blk_512_i,
  input  wire        xfer_busy_i,
  input  wire        xfer_done_i,
  output reg         flush_o,
  output reg         barrier_o,
  output reg         bypass_write_o,
  output reg         sleep_o,
  output reg         xfer_start_o,
  output reg  [4:0]  xfer_task_o,
  output reg  [4:0]  task_probe_id_i_unused_o
);

////////////////////////////////////////////////////////////////////////
// bus clock sampling

  reg        clk_s1_r;
  reg        clk_s2_r;
  reg        clk_s3_r;
  wire       clk_fall = clk_s3_r & ~clk_s2_r;

  // two stages before use; third one only for the edge detector
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
    end else begin
      clk_s1_r <= mmc_clk_i;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end

////////////////////////////////////////////////////////////////////////
// command decode

  wire [7:0] sw_idx   = cmd_arg_i[23:16];
  wire [7:0] sw_val   = cmd_arg_i[15:8];
  wire       sw_wr    = cmd_arg_i[25:24] == 2'h3;
  wire [4:0] tid      = cmd_arg_i[20:16];
  wire       is_cmd   = cmd_valid_i;

  function is_cmd_of;
    input [5:0] idx;
    begin
      is_cmd_of = cmd_valid_i && (cmd_index_i == idx);
    end
  endfunction

  // control state; the task table is a local array of 32 slots
  reg  [7:0]  pon_r;
  reg  [7:0]  bar_en_r;
  reg  [7:0]  flush_ctl_r;
  reg         busy_r;
  reg  [31:0] busy_cnt_r;
  reg  [7:0]  bar_cnt_r;
  reg         param_seen_r;
  reg  [4:0]  param_tid_r;
  reg  [4:0]  scan_r;
  reg  [1:0]  task_st_r [0:31];
  reg         q_nonempty;
  integer     i;
  // one loop index per process, so each index has a single driver
  integer     k;

  // any task not empty blocks a mode switch
  always @* begin
    q_nonempty = 1'b0;
    for (i = 0; i < 32; i = i + 1)
      if (task_st_r[i] != `PCQ_TASK_EMPTY)
        q_nonempty = 1'b1;
  end

  wire sw_cmd     = is_cmd_of(`PCQ_CMD_SWITCH);
  wire sw_illegal = sw_cmd && q_nonempty;                                   // [R21]
  wire sw_ok      = sw_cmd && !q_nonempty && sw_wr;
  wire pon_wr     = sw_ok && ({1'b0, sw_idx} == `PCQ_IDX_POWER_OFF);
  wire pon_zero   = pon_wr && (sw_val == `PCQ_PON_UNSET) &&
                    (pon_r != `PCQ_PON_UNSET);                              // [R7]
  wire pon_bad    = pon_wr && (sw_val > `PCQ_PON_SLEEP);
  wire sleep_cmd  = is_cmd_of(`PCQ_CMD_SLEEP);
  // sleep/wake only from powered-on, or after a sleep notice
  wire sleep_ok   = sleep_cmd && ((pon_r == `PCQ_PON_ON) ||
                    (pon_r == `PCQ_PON_SLEEP));                             // [R8]
  wire exec_cmd   = is_cmd_of(`PCQ_CMD_EXEC_RD) | is_cmd_of(`PCQ_CMD_EXEC_WR);
  wire exec_ok    = exec_cmd && !xfer_busy_i && blk_512_i &&
                    (task_st_r[tid] == `PCQ_TASK_READY);                    // [R20] [R22] [R23]
  wire addr_ok    = is_cmd_of(`PCQ_CMD_TASK_ADDR) && param_seen_r &&
                    (task_st_r[param_tid_r] == `PCQ_TASK_EMPTY);            // [R19]
  wire addr_bad   = is_cmd_of(`PCQ_CMD_TASK_ADDR) && !addr_ok;
  wire flush_wr   = sw_ok && ({1'b0, sw_idx} == `PCQ_IDX_FLUSH_CTRL);
  // a notice is kept across the select/sleep pair used to enter sleep
  wire keep_cmd   = (pon_r == `PCQ_PON_SLEEP) &&
                    (is_cmd_of(`PCQ_CMD_SLEEP) | is_cmd_of(`PCQ_CMD_SELECT));
  wire cmd_err    = sw_illegal | pon_zero | pon_bad | (sleep_cmd & ~sleep_ok) |
                    (exec_cmd & ~exec_ok) | addr_bad;

////////////////////////////////////////////////////////////////////////
// notice byte, busy timing and sleep

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pon_r      <= `PCQ_PON_UNSET;
      busy_r     <= 1'b0;
      busy_cnt_r <= 32'h0000_0000;
      sleep_o    <= 1'b0;
    end else begin
      // a notice write below reloads the counter; the later assignment wins
      if (busy_r) begin
        // backend done or timeout reached releases busy
        if (prep_done_i || busy_cnt_r == 32'h0000_0001)
          busy_r <= 1'b0;                                                   // [R4] [R5] [R9]
        busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
      end
      if (pon_wr && !pon_zero && !pon_bad) begin
        pon_r <= sw_val;                                                    // [R1]
        if (sw_val == `PCQ_PON_SHORT) begin
          busy_r     <= 1'b1;                                               // [R3]
          busy_cnt_r <= SHORT_CYC[31:0];                                    // [R4]
        end else if (sw_val == `PCQ_PON_LONG) begin
          busy_r     <= 1'b1;                                               // [R3]
          busy_cnt_r <= LONG_CYC[31:0];                                     // [R5]
        end else if (sw_val == `PCQ_PON_SLEEP) begin
          busy_r     <= 1'b1;
          busy_cnt_r <= SLEEP_CYC[31:0];                                    // [R9]
        end
      end else if (sleep_ok) begin
        sleep_o <= cmd_arg_i[`PCQ_SLEEP_ARG_BIT];
        if (!cmd_arg_i[`PCQ_SLEEP_ARG_BIT])
          pon_r <= `PCQ_PON_ON;                                             // [R10]
      end else if (priority_interrupt_request_i && busy_r &&
                   pon_r > `PCQ_PON_ON) begin
        pon_r  <= `PCQ_PON_ON;                                              // [R6] [R10]
        busy_r <= 1'b0;
      end else if (is_cmd && !keep_cmd && pon_r > `PCQ_PON_ON) begin
        pon_r <= `PCQ_PON_ON;                                               // [R6]
      end
    end
  end

  // busy driven low on dat0; changes only on a bus clock falling edge,
  // so a stopped bus clock freezes the pin as the host expects
  assign dat0_o = 1'b0;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      dat0_oe_o <= 1'b0;
    else if (clk_fall)
      dat0_oe_o <= busy_r;                                                  // [R3]
  end

////////////////////////////////////////////////////////////////////////
// cache barrier and flush

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bar_en_r       <= 8'h00;
      flush_ctl_r    <= 8'h00;
      bar_cnt_r      <= 8'h00;
      flush_o        <= 1'b0;
      barrier_o      <= 1'b0;
      bypass_write_o <= 1'b0;
    end else begin
      flush_o   <= 1'b0;
      barrier_o <= 1'b0;
      if (sw_ok && ({1'b0, sw_idx} == `PCQ_IDX_BARRIER_EN))
        bar_en_r <= sw_val;
      if (is_cmd_of(`PCQ_CMD_BLKCNT))
        bypass_write_o <= cmd_arg_i[`PCQ_FORCED_BIT] |
                          cmd_arg_i[`PCQ_RELIABLE_BIT];                     // [R17]
      if (flush_wr) begin
        flush_ctl_r <= sw_val;
        if (sw_val[`PCQ_FLUSH_BIT]) begin
          flush_o   <= 1'b1;
          bar_cnt_r <= 8'h00;
        end else if (sw_val[`PCQ_BARRIER_BIT] && BARRIER_ON != 0 &&
                     bar_en_r[0]) begin                                     // [R13] [R16]
          // in-order policy makes a barrier a harmless no-op
          if (FIFO_POLICY == 0) begin                                       // [R18]
            if (bar_cnt_r == `PCQ_BARRIER_LIMIT) begin
              flush_o   <= 1'b1;                                            // [R14]
              bar_cnt_r <= 8'h00;
            end else begin
              barrier_o <= 1'b1;                                            // [R12]
              bar_cnt_r <= bar_cnt_r + 8'h01;
            end
          end
        end
      end else begin
        flush_ctl_r <= 8'h00;  // bits self-clear once acted on
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// task queue

  // one pending task per cycle is promoted; prep is trivially quick here
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (k = 0; k < 32; k = k + 1)
        task_st_r[k] <= `PCQ_TASK_EMPTY;
      param_seen_r <= 1'b0;
      param_tid_r  <= 5'h00;
      scan_r       <= 5'h00;
      xfer_start_o <= 1'b0;
      xfer_task_o  <= 5'h00;
    end else begin
      xfer_start_o <= 1'b0;
      scan_r       <= scan_r + 5'h01;
      if (task_st_r[scan_r] == `PCQ_TASK_PENDING)
        task_st_r[scan_r] <= `PCQ_TASK_READY;                               // [R23]
      if (xfer_done_i)
        task_st_r[xfer_task_o] <= `PCQ_TASK_EMPTY;
      if (is_cmd_of(`PCQ_CMD_TASK_PARAM)) begin
        param_seen_r <= 1'b1;
        param_tid_r  <= tid;
      end else if (is_cmd) begin
        param_seen_r <= 1'b0;
      end
      if (addr_ok)
        task_st_r[param_tid_r] <= `PCQ_TASK_PENDING;                        // [R19]
      if (exec_ok) begin
        task_st_r[tid] <= `PCQ_TASK_RUN;
        xfer_start_o   <= 1'b1;                                             // [R20]
        xfer_task_o    <= tid;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// responses, status and config reads

  // status flags are sticky until a status read; a new error wins
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_o   <= 1'b0;
      resp_err_o     <= 1'b0;
      switch_error_o <= 1'b0;
      illegal_cmd_o  <= 1'b0;
      cfg_rd_data_o  <= 8'h00;
      task_probe_id_i_unused_o <= 5'h00;
    end else begin
      resp_valid_o <= is_cmd;
      resp_err_o   <= cmd_err;
      if (pon_zero | pon_bad)
        switch_error_o <= 1'b1;                                             // [R7]
      else if (is_cmd_of(`PCQ_CMD_STATUS))
        switch_error_o <= 1'b0;                                             // [R7]
      if (sw_illegal | (cmd_err & ~pon_zero & ~pon_bad))
        illegal_cmd_o <= 1'b1;                                              // [R21]
      else if (is_cmd_of(`PCQ_CMD_STATUS))
        illegal_cmd_o <= 1'b0;
      task_probe_id_i_unused_o <= param_tid_r;
      // bytes not kept by this block read as zero
      case (cfg_rd_addr_i)
        `PCQ_IDX_BARRIER_EN:   cfg_rd_data_o <= bar_en_r;
        `PCQ_IDX_FLUSH_CTRL:   cfg_rd_data_o <= flush_ctl_r;
        `PCQ_IDX_POWER_OFF:    cfg_rd_data_o <= pon_r;
        `PCQ_IDX_SLEEP_TIME:   cfg_rd_data_o <= SLEEP_BYTE;
        `PCQ_IDX_FLUSH_POLICY: cfg_rd_data_o <= (FIFO_POLICY != 0) ? 8'h01 : 8'h00; // [R18]
        `PCQ_IDX_BARRIER_CAP:  cfg_rd_data_o <= (BARRIER_ON != 0) ? 8'h01 : 8'h00;  // [R15]
        default:               cfg_rd_data_o <= 8'h00;
      endcase
    end
  end

endmodule // pcq_control
`default_nettype wire

// [test/pcq_host_model.sv]
// host side model: bus clock and DAT0 pull-up
// assumes the bench gates the clock around busy frames
`timescale 1ns/100ps
`default_nettype none
module pcq_host_model (
  // bench control
  input  wire logic run_i,
  // device pins
  input  wire logic dat0_i,
  input  wire logic dat0_oe_i,
  // bus side
  output var  logic mmc_clk_o,
  output wire logic dat0_lvl_o
);
  // parked high between frames; odd start offset keeps phase unrelated
  initial begin
    mmc_clk_o = 1'b1;
    #13;
    forever #40 mmc_clk_o = run_i ? ~mmc_clk_o : 1'b1;
  end
  // pull-up holds the line unless the device sinks it
  assign dat0_lvl_o = dat0_oe_i ? dat0_i : 1'b1;
endmodule // pcq_host_model
`default_nettype wire

// [test/pcq_control_assertions.sv]
// port checker for the power, cache and queue control block
// assumes one clock domain and is bound to every instance
`timescale 1ns/100ps
`default_nettype none
module pcq_control_chk #(
  parameter SHORT_CYC = 20,
  parameter LONG_CYC  = 20,
  parameter SLEEP_CYC = 20
) (
  input wire logic        clk_sys_i, rst_i, cmd_valid_i, dat0_oe_o,
  input wire logic        priority_interrupt_request_i, blk_512_i, xfer_busy_i,
  input wire logic        resp_valid_o, resp_err_o, switch_error_o, illegal_cmd_o,
  input wire logic        flush_o, barrier_o, bypass_write_o, xfer_start_o,
  input wire logic [5:0]  cmd_index_i,
  input wire logic [31:0] cmd_arg_i,
  input wire logic [8:0]  cfg_rd_addr_i,
  input wire logic [7:0]  cfg_rd_data_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  localparam int BUSY_LIM = SHORT_CYC + LONG_CYC + SLEEP_CYC + 40;
  wire logic sw_c = cmd_valid_i && cmd_index_i == 6'h06;
  wire logic ex_c = cmd_valid_i && (cmd_index_i == 6'h2E || cmd_index_i == 6'h2F);
  int busy_n;
  // busy run length; a counter keeps long bounds cheap
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) busy_n <= 0;
    else busy_n <= dat0_oe_o ? busy_n + 1 : 0;
  end
  ////////////////////////////////////////////////////////////
  property p_resp; cmd_valid_i |=> resp_valid_o; endproperty
  a_resp: assert property (p_resp) else $error("late response");
  property p_noresp; !cmd_valid_i |=> !resp_valid_o; endproperty
  a_noresp: assert property (p_noresp) else $error("stray response");
  property p_busy; busy_n < BUSY_LIM; endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
  property p_hpi; priority_interrupt_request_i && dat0_oe_o |-> ##[1:20] !dat0_oe_o; endproperty
  a_hpi: assert property (p_hpi) else $error("busy kept after interrupt");
  property p_ill; $rose(illegal_cmd_o) |-> resp_valid_o && resp_err_o; endproperty
  a_ill: assert property (p_ill) else $error("illegal flag without error response");
  property p_ill_sw;
    sw_c && !switch_error_o ##1 resp_err_o && !switch_error_o |-> illegal_cmd_o;
  endproperty
  a_ill_sw: assert property (p_ill_sw) else $error("refused switch not flagged");
  property p_swe; $rose(switch_error_o) |-> $past(sw_c); endproperty
  a_swe: assert property (p_swe) else $error("switch error without switch");
  property p_blk; ex_c && !blk_512_i |=> resp_err_o && !xfer_start_o; endproperty
  a_blk: assert property (p_blk) else $error("exec accepted without 512");
  property p_start;
    xfer_start_o |-> resp_valid_o && !resp_err_o && $past(ex_c && blk_512_i && !xfer_busy_i);
  endproperty
  a_start: assert property (p_start) else $error("start without good exec");
  property p_bar; barrier_o || flush_o |-> $past(sw_c && cmd_arg_i[23:16] == 8'h20); endproperty
  a_bar: assert property (p_bar) else $error("flush or barrier uncaused");
  property p_byp;
    cmd_valid_i && cmd_index_i == 6'h17 |=> bypass_write_o == ($past(cmd_arg_i[24]) | $past(cmd_arg_i[31]));
  endproperty
  a_byp: assert property (p_byp) else $error("bypass flag wrong");
  property p_cap; cfg_rd_addr_i == 9'h1E6 |=> cfg_rd_data_o == 8'h01; endproperty
  a_cap: assert property (p_cap) else $error("capability byte wrong");
  property p_fifo; cfg_rd_addr_i == 9'h0F0 |=> cfg_rd_data_o[0] == 1'b0; endproperty
  a_fifo: assert property (p_fifo) else $error("policy bit wrong");
  c_start: cover property (xfer_start_o);
  c_bar: cover property (barrier_o);
  c_busy: cover property ($rose(dat0_oe_o));
endmodule // pcq_control_chk
bind pcq_control pcq_control_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
  .SLEEP_CYC(SLEEP_CYC)) u_chk (.*);
`default_nettype wire

// [test/pcq_control_bench.sv]
// bench for the power, cache and queue control block
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module pcq_control_bench;
  logic clk_sys_i = 0, rst_i = 1, run = 0, cv = 0, prio = 0, prep = 0;
  logic blk = 1, xbusy = 0, xdone = 0, rd_v = 0, rd_d = 0;
  logic [5:0] idx = 0;
  logic [31:0] arg = 0, r;
  logic [8:0] raddr = 0;
  logic [4:0] t;
  wire logic mclk, dat0, dat0_oe, lvl, rv, re, swe, ill, fl, ba, byp, slp, xs;
  wire logic [7:0] rdata;
  wire logic [4:0] xt;
  int n_fail = 0, num_checks = 0, n_bar = 0, n_fl = 0;
  logic qe[$];
  logic [7:0] qr[$], qt[$];
  always #5 clk_sys_i = ~clk_sys_i;
  pcq_host_model u_host (.run_i(run), .dat0_i(dat0), .dat0_oe_i(dat0_oe), .mmc_clk_o(mclk),
    .dat0_lvl_o(lvl));
  pcq_control #(.SHORT_CYC(20), .LONG_CYC(20), .SLEEP_CYC(20)) DUT (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .mmc_clk_i(mclk), .dat0_o(dat0), .dat0_oe_o(dat0_oe), .cmd_valid_i(cv),
    .cmd_index_i(idx), .cmd_arg_i(arg), .priority_interrupt_request_i(prio), .resp_valid_o(rv),
    .resp_err_o(re), .switch_error_o(swe), .illegal_cmd_o(ill), .cfg_rd_addr_i(raddr),
    .cfg_rd_data_o(rdata), .prep_done_i(prep), .blk_512_i(blk), .xfer_busy_i(xbusy),
    .xfer_done_i(xdone), .flush_o(fl), .barrier_o(ba), .bypass_write_o(byp), .sleep_o(slp),
    .xfer_start_o(xs), .xfer_task_o(xt), .task_probe_id_i_unused_o());
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_resp(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t response error %b expected %b", $time, g, e);
    end
  endtask
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t value %h expected %h", $time, g, e);
    end
  endtask
  // one-cycle command strobe, expected error noted first
  task automatic cmd(input logic [5:0] i, input logic [31:0] a, input logic e);
    @(posedge clk_sys_i); #1;
    cv = 1; idx = i; arg = a; qe.push_back(e);
    @(posedge clk_sys_i); #1;
    cv = 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys_i); #1;
    raddr = a; rd_v = 1; qr.push_back(e);
    @(posedge clk_sys_i); #1;
    rd_v = 0;
  endtask
  // wait for busy, optionally cut it short, then bound the release
  task automatic busy(input int lim, input logic [1:0] m);
    int k;
    k = 0;
    while (dat0_oe !== 1'b1 && k < 40) begin @(posedge clk_sys_i); #1; k++; end
    chk_val(lvl, 0);
    @(posedge clk_sys_i); #1;
    prio = m[0]; prep = m[1];
    @(posedge clk_sys_i); #1;
    prio = 0; prep = 0; k = 0;
    while (lvl !== 1'b1 && k < lim) begin @(posedge clk_sys_i); #1; k++; end
    chk_val(k < lim, 1);
  endtask
  function automatic logic [31:0] sw(input logic [7:0] b, input logic [7:0] v);
    return {6'h00, 2'h3, b, v, 8'h00};
  endfunction
  // pulse counters and result monitor off the queues
  always @(posedge clk_sys_i) begin
    rd_d <= rd_v; n_bar <= n_bar + ba; n_fl <= n_fl + fl;
  end
  always @(negedge clk_sys_i) begin
    if (rv === 1'b1) chk_resp(re, qe.size() ? qe.pop_front() : 1'bx);
    if (rd_d) chk_val(rdata, qr.pop_front());
    if (xs === 1'b1) chk_val(xt, qt.size() ? qt.pop_front() : 8'hXX);
  end
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(54080));
    repeat (10) @(posedge clk_sys_i);
    #1 rst_i = 0;
    rd(9'h1E6, 8'h01);
    rd(9'h0F0, 8'h00);
    rd(9'h0D8, 8'h08);
    cmd(6'h06, sw(8'h22, 8'h01), 0);
    cmd(6'h06, sw(8'h22, 8'h00), 1);
    chk_val(swe, 1);
    rd(9'h022, 8'h01);
    cmd(6'h0D, 0, 0);
    chk_val(swe, 0);
    run = 1;
    cmd(6'h06, sw(8'h22, 8'h02), 0);
    busy(40, 0);
    cmd(6'h0D, 0, 0);
    rd(9'h022, 8'h01);
    cmd(6'h06, sw(8'h22, 8'h03), 0);
    busy(20, 1);
    rd(9'h022, 8'h01);
    cmd(6'h06, sw(8'h22, 8'h04), 0);
    busy(20, 2);
    rd(9'h022, 8'h04);
    run = 0;
    cmd(6'h05, 32'h0000_8000, 0);
    chk_val(slp, 1);
    cmd(6'h05, 0, 0);
    chk_val(slp, 0);
    rd(9'h022, 8'h01);
    cmd(6'h07, 32'h0001_0000, 0);
    rd(9'h022, 8'h01);
    cmd(6'h06, sw(8'h1F, 8'h01), 0);
    repeat (17) cmd(6'h06, sw(8'h20, 8'h02), 0);
    cmd(6'h06, sw(8'h20, 8'h01), 0);
    repeat (2) @(posedge clk_sys_i);
    chk_val(n_bar, 16);
    chk_val(n_fl, 2);
    for (int j = 0; j < 4; j++) begin
      r = $urandom; r[24] = j[0]; r[31] = j[1];
      cmd(6'h17, r, 0);
      chk_val(byp, j[0] | j[1]);
    end
    t = $urandom_range(31, 0);
    cmd(6'h2D, {11'h000, t, 16'h0000}, 1);
    cmd(6'h2C, {11'h000, t, 16'h0000}, 0);
    cmd(6'h2D, $urandom, 0);
    cmd(6'h0D, 0, 0);
    chk_val(ill, 0);
    cmd(6'h06, sw(8'h22, 8'h01), 1);
    chk_val(ill, 1);
    repeat (40) @(posedge clk_sys_i);
    blk = 0;
    cmd(6'h2F, {11'h000, t, 16'h0000}, 1);
    blk = 1; xbusy = 1;
    cmd(6'h2F, {11'h000, t, 16'h0000}, 1);
    xbusy = 0;
    cmd(6'h2E, {11'h000, t + 5'h01, 16'h0000}, 1);
    qt.push_back({3'h0, t});
    cmd(6'h2F, {11'h000, t, 16'h0000}, 0);
    @(posedge clk_sys_i); #1 xdone = 1;
    @(posedge clk_sys_i); #1 xdone = 0;
    cmd(6'h2F, {11'h000, t, 16'h0000}, 1);
    cmd(6'h0D, 0, 0);
    cmd(6'h06, sw(8'h22, 8'h01), 0);
    chk_val(ill, 0);
    summarize;
  end
endmodule // pcq_control_bench
`default_nettype wire
